// ### verilog/msl_regs.svh
// Purpose: register offsets, field positions, reset values and timing figures of the status lamp controller
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes: times are in milliseconds, the clock rate in kilohertz
`ifndef MSL_REGS_SVH
`define MSL_REGS_SVH

// ==========================================================
// register map
`define MSL_ADDR_W 4
`define MSL_OFF_CTRL 4'h0
`define MSL_OFF_STAT 4'h4
`define MSL_OFF_SHOW 4'h8

// ==========================================================
// control register, write-one pulses, reads as zero
`define MSL_CTRL_START_BIT 0
`define MSL_CTRL_DONE_BIT 1

// ==========================================================
// status register, written by software from the module's status read over the serial link
`define MSL_STAT_W 4
`define MSL_STAT_RST 4'h0
`define MSL_STAT_OPER_BIT 0
`define MSL_STAT_STANDBY_BIT 1
`define MSL_STAT_RECOV_BIT 2
`define MSL_STAT_FATAL_BIT 3

// ==========================================================
// display register fields
`define MSL_SHOW_MODE_LSB 0
`define MSL_SHOW_GREEN_BIT 3
`define MSL_SHOW_RED_BIT 4
`define MSL_SHOW_BUSY_BIT 5
`define MSL_SHOW_NETGO_BIT 6

// ==========================================================
// responses and timing
`define MSL_RESP_OKAY 2'h0
`define MSL_RESP_SLVERR 2'h2
`define MSL_CLK_KHZ 250000
`define MSL_TEST_STEP_MS 250
`define MSL_FLASH_HALF_MS 500

`endif

// ### verilog/msl_pkg.sv
// Purpose: types and shared functions of the status lamp controller
// Assumes: msl_regs.svh holds every number
// Notes: none
package msl_pkg;
`include "msl_regs.svh"

  typedef enum logic [2:0] {
    MSL_M_OFF,
    MSL_M_GREEN,
    MSL_M_GREEN_FLASH,
    MSL_M_RED_FLASH,
    MSL_M_RED,
    MSL_M_TEST_GREEN,
    MSL_M_TEST_RED
  } msl_mode_e;

  typedef enum logic [1:0] {
    MSL_S_IDLE,
    MSL_S_GREEN,
    MSL_S_RED,
    MSL_S_HOLD
  } msl_seq_e;

  // a mapped register: word aligned and not past the last one
  function automatic logic msl_hit(input logic [`MSL_ADDR_W-1:0] addr);
    msl_hit = (addr[1:0] == 2'h0) && (addr <= `MSL_OFF_SHOW);
  endfunction

  // lamp colours for a display mode, bit 1 green, bit 0 red
  function automatic logic [1:0] msl_lamp(input msl_mode_e mode, input logic phase);
    case (mode)
      MSL_M_GREEN, MSL_M_TEST_GREEN: msl_lamp = 2'h2;
      MSL_M_GREEN_FLASH: msl_lamp = {phase, 1'b0};
      MSL_M_RED_FLASH: msl_lamp = {1'b0, phase};
      MSL_M_RED, MSL_M_TEST_RED: msl_lamp = 2'h1;
      default: msl_lamp = 2'h0;
    endcase
  endfunction
endpackage

// ### verilog/msl_timer.sv
// Purpose: wrapping cycle counter that pulses once every LEN cycles
// Assumes: LEN at least 1
// Notes: clear restarts the count, the pulse follows LEN + 1 cycles after the clear
`timescale 1ns/1ps
module msl_timer #(
  parameter int unsigned LEN = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  output logic done
);
  import msl_pkg::*;

  localparam int unsigned W = $clog2(LEN + 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic last;

  assign last = (cnt_q == W'(LEN - 1));
  assign done = done_q;

  always_comb begin
    cnt_d = last ? '0 : cnt_q + W'(1);
    done_d = last && !clear;
    if (clear) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  period_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    done_q |-> $past(cnt_q) == W'(LEN - 1) && cnt_q == '0)
    else $error("timer pulse not at end of period");
endmodule

// ### verilog/msl_axil.sv
// Purpose: AXI4-Lite slave handshake for the status lamp controller registers
// Assumes: master holds address and data until taken, one write and one read at a time
// Notes: write taken one cycle after both valids, answer one cycle later; read likewise
`timescale 1ns/1ps
`include "msl_regs.svh"
module msl_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`MSL_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`MSL_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rd_data,
  output logic wr_en
);
  import msl_pkg::*;

  logic awready_q, awready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  assign awready = awready_q;
  assign wready = awready_q;
  assign wr_en = awready_q;
  assign arready = arready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  always_comb begin
    awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
    arready_d = arvalid && !arready_q && !rvalid_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awready_q) begin
      bvalid_d = 1'b1;
      bresp_d = msl_hit(awaddr) ? `MSL_RESP_OKAY : `MSL_RESP_SLVERR;
    end
    if (arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = msl_hit(araddr) ? `MSL_RESP_OKAY : `MSL_RESP_SLVERR;
      rdata_d = rd_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      awready_q <= awready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    awready_q |=> bvalid_q)
    else $error("write taken without response");
endmodule

// ### verilog/msl_top.sv
// Purpose: host-side driver of the bi-colour module state lamp, with the power-up test sequence
// Assumes: software reads the communication module over the serial link and copies its status here
// Notes: all lamp and handshake outputs are registered
//
// What this block does
// R1: host drives both colours of the bi-colour lamp itself
// R2: module status reaches the host by serial link
// R3: operational: lamp steady green
// R4: standby, not configured: lamp flashes green
// R5: recoverable fault or bad configuration: flashes red
// R6: non-recoverable fault: lamp steady red
// R7: self-test: green, red, then green until done
// R8: module lamp test before or with network tests
// R9: several network lamp tests may run serially
// R10: after self-test, show normal operational state
// R11: no address conflict detection, no state
// R12: flashing uses one second period, half duty
// R13: priority: fatal, recoverable, standby, operational
`timescale 1ns/1ps
`include "msl_regs.svh"
module msl_top #(
  parameter int unsigned FLASH_HALF_CYC = `MSL_FLASH_HALF_MS * `MSL_CLK_KHZ,
  parameter int unsigned TEST_STEP_CYC = `MSL_TEST_STEP_MS * `MSL_CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`MSL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MSL_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic module_state_lamp_green,
  output logic module_state_lamp_red,
  output logic net_test_go
);
  import msl_pkg::*;

  // ==========================================================
  // bus slave
  logic wr_en;
  logic [31:0] rd_data;

  msl_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rd_data(rd_data),
    .wr_en(wr_en)
  );

  logic ctrl_wr, stat_wr, start_wr, done_wr;

  assign ctrl_wr = wr_en && s_axi_wstrb[0] && (s_axi_awaddr == `MSL_OFF_CTRL);
  assign stat_wr = wr_en && s_axi_wstrb[0] && (s_axi_awaddr == `MSL_OFF_STAT);
  assign start_wr = ctrl_wr && s_axi_wdata[`MSL_CTRL_START_BIT];
  assign done_wr = ctrl_wr && s_axi_wdata[`MSL_CTRL_DONE_BIT];

  // ==========================================================
  // timers
  logic flash_tick, step_tick, step_clear;

  msl_timer #(.LEN(FLASH_HALF_CYC)) u_flash (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(1'b0),
    .done(flash_tick)
  );

  msl_timer #(.LEN(TEST_STEP_CYC)) u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(step_clear),
    .done(step_tick)
  );

  // ==========================================================
  // status copy and self-test sequence
  logic [`MSL_STAT_W-1:0] stat_q, stat_d;
  msl_seq_e seq_q, seq_d;
  logic done_seen_q, done_seen_d;

  // status bits carry no address conflict indication
  always_comb begin
    stat_d = stat_q;
    if (stat_wr) begin
      stat_d = s_axi_wdata[`MSL_STAT_W-1:0]; // R2 R11
    end
  end

  assign step_clear = start_wr && (seq_q == MSL_S_IDLE);

  always_comb begin
    seq_d = seq_q;
    done_seen_d = done_seen_q;
    case (seq_q)
      MSL_S_IDLE: begin
        if (start_wr) begin
          seq_d = MSL_S_GREEN; // R7
          done_seen_d = 1'b0;
        end
      end
      MSL_S_GREEN: begin
        if (step_tick) begin
          seq_d = MSL_S_RED; // R7
        end
      end
      MSL_S_RED: begin
        if (step_tick) begin
          seq_d = MSL_S_HOLD; // R7
        end
      end
      MSL_S_HOLD: begin
        if (done_seen_q) begin
          seq_d = MSL_S_IDLE; // R10
        end
      end
      default: seq_d = MSL_S_IDLE;
    endcase
    // an early completion is kept so that the hold ends at once
    if (done_wr && (seq_q != MSL_S_IDLE)) begin
      done_seen_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= `MSL_STAT_RST;
      seq_q <= MSL_S_IDLE;
      done_seen_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      seq_q <= seq_d;
      done_seen_q <= done_seen_d;
    end
  end

  // ==========================================================
  // display mode and lamp drive
  msl_mode_e mode_q, mode_d;
  logic flash_q, flash_d;
  logic green_q, green_d, red_q, red_d, net_go_q, net_go_d;

  always_comb begin
    flash_d = flash_tick ? !flash_q : flash_q; // R12
    case (seq_d)
      MSL_S_GREEN, MSL_S_HOLD: mode_d = MSL_M_TEST_GREEN; // R7
      MSL_S_RED: mode_d = MSL_M_TEST_RED; // R7
      default: begin
        if (stat_q[`MSL_STAT_FATAL_BIT]) begin
          mode_d = MSL_M_RED; // R6 R13
        end else if (stat_q[`MSL_STAT_RECOV_BIT]) begin
          mode_d = MSL_M_RED_FLASH; // R5 R13
        end else if (stat_q[`MSL_STAT_STANDBY_BIT]) begin
          mode_d = MSL_M_GREEN_FLASH; // R4 R13
        end else if (stat_q[`MSL_STAT_OPER_BIT]) begin
          mode_d = MSL_M_GREEN; // R3 R10
        end else begin
          mode_d = MSL_M_OFF;
        end
      end
    endcase
    {green_d, red_d} = msl_lamp(mode_d, flash_d); // R1
    // network lamp tests are released together with the module lamp test
    net_go_d = (seq_d != MSL_S_IDLE); // R8 R9
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MSL_M_OFF;
      flash_q <= 1'b0;
      green_q <= 1'b0;
      red_q <= 1'b0;
      net_go_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      flash_q <= flash_d;
      green_q <= green_d;
      red_q <= red_d;
      net_go_q <= net_go_d;
    end
  end

  assign module_state_lamp_green = green_q;
  assign module_state_lamp_red = red_q;
  assign net_test_go = net_go_q;

  // ==========================================================
  // flash run length, watched by the period check
  // the run count starts at reset, a cycle earlier than after a pulse, so the first pulse reads one more and only later ones are judged
  logic [31:0] flash_run_q, flash_run_d;
  logic flash_seen_q, flash_seen_d;

  always_comb begin
    flash_run_d = flash_run_q + 32'h0000_0001;
    flash_seen_d = flash_seen_q;
    if (flash_tick) begin
      flash_run_d = 32'h0000_0000;
      flash_seen_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_run_q <= 32'h0000_0000;
      flash_seen_q <= 1'b0;
    end else begin
      flash_run_q <= flash_run_d;
      flash_seen_q <= flash_seen_d;
    end
  end

  // ==========================================================
  // read data
  always_comb begin
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      `MSL_OFF_STAT: rd_data[`MSL_STAT_W-1:0] = stat_q;
      `MSL_OFF_SHOW: begin
        rd_data[`MSL_SHOW_MODE_LSB +: 3] = mode_q;
        rd_data[`MSL_SHOW_GREEN_BIT] = green_q;
        rd_data[`MSL_SHOW_RED_BIT] = red_q;
        rd_data[`MSL_SHOW_BUSY_BIT] = (seq_q != MSL_S_IDLE);
        rd_data[`MSL_SHOW_NETGO_BIT] = net_go_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // checks
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  steady_green_a: assert property (mode_q == MSL_M_GREEN |-> green_q && !red_q) // R3
    else $error("operational lamp not steady green");
  green_flash_a: assert property (mode_q == MSL_M_GREEN_FLASH |-> green_q == flash_q && !red_q) // R4
    else $error("standby lamp not flashing green");
  red_flash_a: assert property (mode_q == MSL_M_RED_FLASH |-> red_q == flash_q && !green_q) // R5
    else $error("recoverable fault lamp not flashing red");
  steady_red_a: assert property (mode_q == MSL_M_RED |-> red_q && !green_q) // R6
    else $error("fatal fault lamp not steady red");
  test_order_a: assert property ($rose(seq_q == MSL_S_RED) |-> $past(seq_q) == MSL_S_GREEN && red_q && !green_q) // R7
    else $error("test red phase out of order");
  test_hold_a: assert property (seq_q == MSL_S_HOLD && !done_seen_q |=> seq_q == MSL_S_HOLD && green_q) // R7
    else $error("test hold left early");
  net_after_a: assert property ($rose(net_go_q) |-> seq_q == MSL_S_GREEN && green_q) // R8
    else $error("network test released before module test");
  test_exit_a: assert property (seq_q == MSL_S_HOLD && done_seen_q |=> seq_q == MSL_S_IDLE && !net_go_q) // R10
    else $error("self-test did not return to normal display");
  fatal_first_a: assert property (seq_q == MSL_S_IDLE && !start_wr && stat_q[`MSL_STAT_FATAL_BIT]
    |=> mode_q == MSL_M_RED) // R13
    else $error("fatal fault not given priority");
  recov_next_a: assert property (seq_q == MSL_S_IDLE && !start_wr && stat_q[3:2] == 2'h1
    |=> mode_q == MSL_M_RED_FLASH) // R13
    else $error("recoverable fault not over standby");
  stat_copy_a: assert property (stat_wr |=> stat_q == $past(s_axi_wdata[`MSL_STAT_W-1:0])) // R2
    else $error("status write lost");
  flash_period_a: assert property (flash_tick && flash_seen_q |-> flash_run_q == 32'(FLASH_HALF_CYC - 1)) // R12
    else $error("flash half period wrong");
  colour_excl_a: assert property (!(green_q && red_q)) // R1
    else $error("both lamp colours lit");
  net_idle_a: assert property (seq_q == MSL_S_IDLE |-> !net_go_q) // R8
    else $error("network test released without module test");
  test_start_a: assert property (start_wr && seq_q == MSL_S_IDLE |=> seq_q == MSL_S_GREEN && green_q && net_go_q) // R7
    else $error("self-test did not open green");
  done_keep_a: assert property (done_wr && seq_q != MSL_S_IDLE |=> done_seen_q) // R10
    else $error("test completion lost");
  lamp_off_a: assert property (seq_q == MSL_S_IDLE && !start_wr && stat_q == 4'h0 |=> !green_q && !red_q) // R10
    else $error("lamp lit with no status");

  test_done_c: cover property (seq_q == MSL_S_HOLD ##1 seq_q == MSL_S_IDLE);
  red_flash_c: cover property (mode_q == MSL_M_RED_FLASH && $changed(red_q));
  steady_red_c: cover property (mode_q == MSL_M_RED);
  green_flash_c: cover property (mode_q == MSL_M_GREEN_FLASH && $rose(green_q));
  test_red_c: cover property (seq_q == MSL_S_RED);
endmodule

// ### bench/msl_comm_model.sv
// Purpose: behavioural communication module that hands its status word to the host
// Assumes: the serial link is abstracted to a word refreshed every clock
// Notes: bit order matches the host status register
`timescale 1ns/1ps
module msl_comm_model (
  input wire logic aclk,
  input wire logic configured,
  input wire logic bad_cfg,
  input wire logic recov,
  input wire logic fatal,
  output logic [3:0] status_q
);
  // ========
  // status word
  // bad configuration reads as a recoverable fault; no address conflict bit exists
  always_ff @(posedge aclk) begin
    status_q <= {fatal, recov | bad_cfg, !configured, configured & !bad_cfg};
  end
endmodule

// ### bench/tb_top.sv
// Purpose: self-checking bench of the module state lamp controller
// Assumes: short flash and test step counts, status copied from the model by software
// Notes: bus tasks wait on handshakes, the watchdog cuts hangs
`timescale 1ns/1ps
`include "msl_regs.svh"
module tb_top;
  import msl_pkg::*;
  logic aclk, aresetn;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic module_state_lamp_green, module_state_lamp_red, net_test_go;
  logic cfg, bad, rec, fat;
  logic [3:0] st;
  int errors, samples_checked;

  msl_top #(.FLASH_HALF_CYC(8), .TEST_STEP_CYC(5)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .module_state_lamp_green, .module_state_lamp_red, .net_test_go);
  msl_comm_model comm (.aclk, .configured(cfg), .bad_cfg(bad), .recov(rec), .fatal(fat), .status_q(st));

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  // ========
  // common tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_arvalid);
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // counts lit cycles of each colour over two flash half periods
  task automatic lamps(output logic [31:0] g, output logic [31:0] r);
    g = 32'h0;
    r = 32'h0;
    repeat (16) begin
      @(posedge aclk);
      g += module_state_lamp_green;
      r += module_state_lamp_red;
    end
  endtask

  // ========
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk(module_state_lamp_green | module_state_lamp_red | net_test_go, 32'h0);
    rd(`MSL_OFF_STAT, d, r);
    chk(d, 32'h0);
    rd(`MSL_OFF_CTRL, d, r);
    chk(d, 32'h0);
    rd(4'hc, d, r);
    chk(r, `MSL_RESP_SLVERR);
    chk(d, 32'h0);
    wr(4'h2, 32'h0000_000f, r);
    chk(r, `MSL_RESP_SLVERR);
    wr(`MSL_OFF_SHOW, 32'h0000_00ff, r);
    chk(r, `MSL_RESP_OKAY);
    rd(`MSL_OFF_SHOW, d, r);
    chk(d, 32'h0);
  endtask

  task automatic t_prio;
    logic [3:0] sc [5] = '{4'b1000, 4'b0000, 4'b1100, 4'b0010, 4'b1011};
    logic [3:0] es [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'hd};
    logic [31:0] eg [5] = '{32'd16, 32'd8, 32'd0, 32'd0, 32'd0};
    logic [31:0] er [5] = '{32'd0, 32'd0, 32'd8, 32'd8, 32'd16};
    logic [2:0] em [5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
    logic [31:0] d, g, rr, n;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      {cfg, bad, rec, fat} <= sc[i];
      repeat (2) @(posedge aclk);
      wr(`MSL_OFF_STAT, {28'h0, st}, r);
      rd(`MSL_OFF_STAT, d, r);
      chk(d, {28'h0, es[i]});
      repeat (3) @(posedge aclk);
      lamps(g, rr);
      chk(g, eg[i]);
      chk(rr, er[i]);
      rd(`MSL_OFF_SHOW, d, r);
      chk(d[2:0], em[i]);
      if (eg[i] == 32'd8 || er[i] == 32'd8) begin
        n = 32'h0;
        while (module_state_lamp_green | module_state_lamp_red) @(posedge aclk);
        while (!(module_state_lamp_green | module_state_lamp_red)) @(posedge aclk);
        while (module_state_lamp_green | module_state_lamp_red) begin
          n++;
          @(posedge aclk);
        end
        chk(n, 32'd8);
      end
    end
  endtask

  task automatic t_self;
    logic [31:0] n, d, g, rr;
    logic [1:0] r;
    wr(`MSL_OFF_STAT, 32'h0, r);
    wr(`MSL_OFF_CTRL, 32'h0000_0001, r);
    n = 32'h0;
    while (!module_state_lamp_green && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk(net_test_go, 32'h1);
    n = 32'h0;
    while (module_state_lamp_green) begin
      n++;
      @(posedge aclk);
    end
    chk(n, 32'd6);
    n = 32'h0;
    while (module_state_lamp_red) begin
      n++;
      @(posedge aclk);
    end
    chk(n, 32'd5);
    wr(`MSL_OFF_STAT, 32'h0000_0004, r);
    repeat (10) @(posedge aclk);
    chk({module_state_lamp_green, module_state_lamp_red}, 32'h2);
    rd(`MSL_OFF_SHOW, d, r);
    chk(d, 32'h0000_006d);
    wr(`MSL_OFF_CTRL, 32'h0000_0002, r);
    repeat (4) @(posedge aclk);
    chk(net_test_go, 32'h0);
    lamps(g, rr);
    chk(g, 32'd0);
    chk(rr, 32'd8);
  endtask

  task automatic results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ========
  // main sequence and watchdog
  initial begin
    errors = 0;
    samples_checked = 0;
    aresetn = 1'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cfg, bad, rec, fat} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_prio();
    t_self();
    results();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end
endmodule
